// *** pkg/pal_pkg.sv ***
// Constants, types and register map of the PHY link control block
// Function
// - Advertise pause bits, reset values from straps
// - No bursts: speed from symbols/pulses, half duplex
// - Parallel-detected link clears partner-able bit
// - Fault during parallel detection sets fault bit
// - Store partner word; parallel detect stores speed
// - Restart bit restarts negotiation from any state
// - Signal loss resumes negotiation automatically
// - Software restart halts traffic, waits link break
// - Restart negotiation after loader updates straps
// - Negotiation off forces speed and duplex bits
// - Forced bits ignored while negotiation enabled
// - Half duplex: CRS on tx/rx, collision flagged
// - Full duplex: CRS on rx only, no collision
// - Detect partner pairs, swap own pair assignment
// - Straps select automatic or fixed crossover
// - Soft control bit selects register crossover bits
// - Forced modes: extend-manual bit lengthens switching
// - Power-down mode: extend bit lengthens switching
// - No automatic crossover in fibre mode
// - Registers reached over serial management port
// - Unimplemented register reads return all ones
// - Resolve 100F, 100H, 10F, 10H in order
// - Control bit 9 high requests restart
// - Ack the word; partner change restarts negotiation
package pal_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_PDCFG = 5'h10;
  localparam logic [4:0] REG_SPEC = 5'h1b;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SWRESET = 15;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  localparam int ADV_ASYM = 11;
  localparam int ADV_SYM = 10;
  localparam int ABIL_LSB = 5;
  localparam int ABIL_100H = 7;
  localparam int ABIL_10H = 5;
  localparam int LCW_ACK = 14;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_ABLE = 0;
  localparam int SPEC_SOFT = 15;
  localparam int SPEC_AUTO = 14;
  localparam int SPEC_STATE = 13;
  localparam int PDCFG_EXT_MAN = 1;
  localparam int PDCFG_EXT_ENERGY_DETECT_POWER_DOWN = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] STAT_CAPS = 16'h7809;
  localparam logic [15:0] ADV_RST = 16'h01e1;
  localparam logic [15:0] LPA_SELECTOR = 16'h0001;
  localparam logic [15:0] UNMAPPED_VAL = 16'hffff;
  localparam logic CTRL_AN_EN_RST = 1'b1;
  localparam logic CTRL_SPEED_RST = 1'b1;
  localparam logic CTRL_DUPLEX_RST = 1'b1;
  // ----------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [4:0] HDR_LAST = 5'd12;
  localparam logic [4:0] DATA_LAST = 5'd15;
  localparam logic [4:0] SKIP_LAST = 5'd17;
  localparam logic [4:0] PHY_ADDR_RST = 5'h01;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BREAK_LINK_MS = 1200;
  localparam int BREAK_LINK_CYC = BREAK_LINK_MS * (CLK_HZ / 1000);
  localparam int MDIX_SWITCH_MS = 60;
  localparam int MDIX_SWITCH_CYC = MDIX_SWITCH_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 24;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {AN_OFF, AN_BREAK, AN_LISTEN, AN_ACK, AN_LINK} pal_an_state_t;
  typedef enum logic [2:0] {MI_IDLE, MI_HDR, MI_TA_RD, MI_RD, MI_TA_WR, MI_WR, MI_SKIP} pal_mi_state_t;
  typedef struct packed {
    logic pause_asym;
    logic pause_sym;
    logic [1:0] auto_mdix;
    logic [1:0] manual_mdix;
  } pal_strap_t;
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic an_complete;
  } pal_link_stat_t;
endpackage

// *** core/pal_link_ctrl.sv ***
// Negotiation, crossover and management register logic of one PHY port
`timescale 1ns/1ps
module pal_link_ctrl #(
  parameter logic [4:0] PHY_ADDR = pal_pkg::PHY_ADDR_RST,
  parameter int BREAK_CYC = pal_pkg::BREAK_LINK_CYC,
  parameter int SWITCH_CYC = pal_pkg::MDIX_SWITCH_CYC
) (
  input wire logic i_ref_clk, // 10 MHz clock
  input wire logic i_reset, // Sync reset, active high
  input wire pal_pkg::pal_strap_t i_straps, // Configuration straps
  input wire logic i_loader_done, // Pulse: loader updated straps
  input wire logic i_flp_word_valid, // Pulse: partner word received
  input wire logic [15:0] i_flp_word, // Partner link code word
  input wire logic i_pd_100_seen, // 100M symbols seen, no bursts
  input wire logic i_pd_10_seen, // Normal link pulses, no bursts
  input wire logic i_pd_fault, // Parallel detection fault
  input wire logic i_signal_lost, // Receive signal lost
  input wire logic i_tx_active, // Own transmit activity
  input wire logic i_rx_active, // Receive activity
  input wire logic i_fx_mode, // Port in fibre mode
  input wire logic i_energy_detect_power_down_enable, // Energy detect power-down on
  input wire logic i_partner_pairs_found, // Partner pairs detected
  input wire logic i_mdc, // Management clock level
  input wire logic i_mdio, // Management data in
  output logic o_mdio, // Management data out
  output logic o_mdio_oe, // Management data drive enable
  output pal_pkg::pal_link_stat_t o_link, // Resolved link status
  output logic [15:0] o_lcw, // Link code word to send
  output logic o_lcw_send, // Sending bursts
  output logic o_txrx_halt, // Traffic stopped during break
  output logic o_crs, // Carrier sense
  output logic o_col, // Collision
  output logic o_mdix_swap // Pair assignment swapped
);
  import pal_pkg::*;

  function automatic logic [1:0] resolve(input logic [3:0] common);
    // Returns {speed_100, full_duplex}
    if (common[3]) begin
      resolve = 2'b11;
    end else if (common[2]) begin
      resolve = 2'b10;
    end else if (common[1]) begin
      resolve = 2'b01;
    end else begin
      resolve = 2'b00;
    end
  endfunction

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  pal_mi_state_t mi_st_r, mi_st_nxt;
  logic mdc_q_r, mdc_q_nxt;
  logic prev_bit_r, prev_bit_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic wr_stb_r, wr_stb_nxt;
  logic exp_rd_r, exp_rd_nxt;
  logic [15:0] rd_val;
  logic rise;

  // Control and negotiation state
  pal_an_state_t an_st_r, an_st_nxt;
  pal_strap_t strap_r, strap_nxt;
  logic an_en_r, an_en_nxt;
  logic speed_r, speed_nxt;
  logic duplex_r, duplex_nxt;
  logic [15:0] adv_r, adv_nxt;
  logic [15:0] lpa_r, lpa_nxt;
  logic lp_able_r, lp_able_nxt;
  logic pd_fault_r, pd_fault_nxt;
  logic [2:0] spec_r, spec_nxt;
  logic [1:0] pdcfg_r, pdcfg_nxt;
  logic [1:0] res_r, res_nxt;
  logic an_done_r, an_done_nxt;
  logic [TIMER_W-1:0] tmr_r, tmr_nxt;
  pal_link_stat_t link_r, link_nxt;
  logic link_up;

  // Crossover state
  logic swap_r, swap_nxt;
  logic [TIMER_W-1:0] sw_tmr_r, sw_tmr_nxt;

  assign rise = i_mdc & ~mdc_q_r;

  // Address as its last bit arrives, so the reply is latched with the header
  always_comb begin
    case ({sh_r[3:0], i_mdio})
      REG_CTRL: rd_val = {1'b0, 1'b0, speed_r, an_en_r, 3'h0, duplex_r, 8'h00};
      REG_STAT: rd_val = STAT_CAPS | (16'(an_done_r) << STAT_AN_DONE) | (16'(link_r.link_up) << STAT_LINK);
      REG_ADV: rd_val = adv_r;
      REG_LPA: rd_val = lpa_r;
      REG_EXP: rd_val = (16'(pd_fault_r) << EXP_PD_FAULT) | (16'(lp_able_r) << EXP_LP_ABLE);
      REG_PDCFG: rd_val = {14'h0000, pdcfg_r};
      REG_SPEC: rd_val = {spec_r, 13'h0000};
      default: rd_val = UNMAPPED_VAL;
    endcase
  end

  always_comb begin
    mi_st_nxt = mi_st_r;
    mdc_q_nxt = i_mdc;
    prev_bit_nxt = prev_bit_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    sh_nxt = sh_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    wr_stb_nxt = 1'b0;
    exp_rd_nxt = 1'b0;
    if (rise) begin
      case (mi_st_r)
        MI_IDLE: begin
          // Start bit: a zero after a one of the preamble
          if (prev_bit_r && !i_mdio) begin
            mi_st_nxt = MI_HDR;
            cnt_nxt = 5'd0;
            sh_nxt = 16'h0000;
          end
          prev_bit_nxt = i_mdio;
        end
        MI_HDR: begin
          sh_nxt = {sh_r[14:0], i_mdio};
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == HDR_LAST) begin
            addr_nxt = sh_nxt[4:0];
            cnt_nxt = 5'd0;
            if (sh_nxt[9:5] != PHY_ADDR || !sh_nxt[12]) begin
              mi_st_nxt = MI_SKIP;
            end else if (sh_nxt[11:10] == OP_READ) begin
              mi_st_nxt = MI_TA_RD;
              sh_nxt = rd_val;
              exp_rd_nxt = (addr_nxt == REG_EXP);
            end else if (sh_nxt[11:10] == OP_WRITE) begin
              mi_st_nxt = MI_TA_WR;
            end else begin
              mi_st_nxt = MI_SKIP;
            end
          end
        end
        MI_TA_RD: begin
          oe_nxt = 1'b1;
          if (cnt_r == 5'd0) begin
            out_nxt = 1'b0;
            cnt_nxt = 5'd1;
          end else begin
            mi_st_nxt = MI_RD;
            out_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            cnt_nxt = 5'd0;
          end
        end
        MI_RD: begin
          if (cnt_r == DATA_LAST) begin
            mi_st_nxt = MI_IDLE;
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            prev_bit_nxt = 1'b0;
          end else begin
            out_nxt = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
            cnt_nxt = cnt_r + 5'd1;
          end
        end
        MI_TA_WR: begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == 5'd1) begin
            mi_st_nxt = MI_WR;
            cnt_nxt = 5'd0;
          end
        end
        MI_WR: begin
          sh_nxt = {sh_r[14:0], i_mdio};
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == DATA_LAST) begin
            mi_st_nxt = MI_IDLE;
            wr_stb_nxt = 1'b1;
            prev_bit_nxt = 1'b0;
          end
        end
        MI_SKIP: begin
          // Frame for another port, or with a bad start bit or opcode: let its tail pass unparsed
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r == SKIP_LAST) begin
            mi_st_nxt = MI_IDLE;
            prev_bit_nxt = 1'b0;
          end
        end
        default: mi_st_nxt = MI_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mi_st_r <= MI_IDLE;
      mdc_q_r <= 1'b0;
      prev_bit_r <= 1'b0;
      cnt_r <= 5'd0;
      addr_r <= 5'd0;
      sh_r <= 16'h0000;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      wr_stb_r <= 1'b0;
      exp_rd_r <= 1'b0;
    end else begin
      mi_st_r <= mi_st_nxt;
      mdc_q_r <= mdc_q_nxt;
      prev_bit_r <= prev_bit_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      wr_stb_r <= wr_stb_nxt;
      exp_rd_r <= exp_rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control registers and negotiation
  // ----------------------------------------------------------------
  always_comb begin
    logic restart;
    logic soft_rst;
    restart = 1'b0;
    soft_rst = 1'b0;
    an_st_nxt = an_st_r;
    strap_nxt = strap_r;
    an_en_nxt = an_en_r;
    speed_nxt = speed_r;
    duplex_nxt = duplex_r;
    adv_nxt = adv_r;
    lpa_nxt = lpa_r;
    lp_able_nxt = lp_able_r;
    pd_fault_nxt = pd_fault_r;
    spec_nxt = spec_r;
    pdcfg_nxt = pdcfg_r;
    res_nxt = res_r;
    an_done_nxt = an_done_r;
    tmr_nxt = tmr_r;
    if (exp_rd_r) begin
      pd_fault_nxt = 1'b0;
    end
    if (wr_stb_r) begin
      case (addr_r)
        REG_CTRL: begin
          soft_rst = sh_r[CTRL_SWRESET];
          an_en_nxt = sh_r[CTRL_AN_EN];
          speed_nxt = sh_r[CTRL_SPEED];
          duplex_nxt = sh_r[CTRL_DUPLEX];
          restart = sh_r[CTRL_RESTART];
        end
        REG_ADV: begin
          adv_nxt[ADV_ASYM] = sh_r[ADV_ASYM];
          adv_nxt[ADV_SYM] = sh_r[ADV_SYM];
          adv_nxt[ABIL_LSB +: 4] = sh_r[ABIL_LSB +: 4];
        end
        REG_SPEC: spec_nxt = sh_r[15:13];
        REG_PDCFG: pdcfg_nxt = sh_r[1:0];
        default: ;
      endcase
    end
    case (an_st_r)
      AN_OFF: begin
        if (an_en_r) begin
          an_st_nxt = AN_LISTEN;
        end
      end
      AN_BREAK: begin
        tmr_nxt = tmr_r + TIMER_W'(1);
        if (tmr_r == TIMER_W'(BREAK_CYC - 1)) begin
          an_st_nxt = AN_LISTEN;
        end
      end
      AN_LISTEN: begin
        if (i_flp_word_valid) begin
          lpa_nxt = i_flp_word;
          lp_able_nxt = 1'b1;
          an_st_nxt = AN_ACK;
        end else if (i_pd_fault) begin
          pd_fault_nxt = 1'b1;
        end else if (i_pd_100_seen || i_pd_10_seen) begin
          lpa_nxt = LPA_SELECTOR | (16'(i_pd_100_seen) << ABIL_100H) | (16'(!i_pd_100_seen) << ABIL_10H);
          lp_able_nxt = 1'b0;
          res_nxt = {i_pd_100_seen, 1'b0};
          an_done_nxt = 1'b1;
          an_st_nxt = AN_LINK;
        end
      end
      AN_ACK: begin
        if (i_flp_word_valid) begin
          if (i_flp_word[13:0] != lpa_r[13:0]) begin
            an_st_nxt = AN_LISTEN;
          end else begin
            lpa_nxt = i_flp_word;
            res_nxt = resolve(adv_r[ABIL_LSB +: 4] & i_flp_word[ABIL_LSB +: 4]);
            an_done_nxt = 1'b1;
            an_st_nxt = AN_LINK;
          end
        end
      end
      AN_LINK: begin
        if (i_signal_lost) begin
          an_st_nxt = AN_LISTEN;
          an_done_nxt = 1'b0;
        end
      end
      default: an_st_nxt = AN_OFF;
    endcase
    if (i_loader_done) begin
      strap_nxt = i_straps;
      adv_nxt[ADV_ASYM] = i_straps.pause_asym;
      adv_nxt[ADV_SYM] = i_straps.pause_sym;
      an_st_nxt = AN_LISTEN;
      an_done_nxt = 1'b0;
    end
    if (restart) begin
      an_st_nxt = AN_BREAK;
      tmr_nxt = '0;
      an_done_nxt = 1'b0;
    end
    if (!an_en_nxt) begin
      an_st_nxt = AN_OFF;
      an_done_nxt = 1'b0;
    end
    // Fault arriving with the clearing read still sticks
    if (an_st_r == AN_LISTEN && i_pd_fault && !i_flp_word_valid) begin
      pd_fault_nxt = 1'b1;
    end
    if (soft_rst) begin
      an_st_nxt = AN_OFF;
      an_en_nxt = CTRL_AN_EN_RST;
      speed_nxt = CTRL_SPEED_RST;
      duplex_nxt = CTRL_DUPLEX_RST;
      adv_nxt = ADV_RST | (16'(strap_r.pause_asym) << ADV_ASYM) | (16'(strap_r.pause_sym) << ADV_SYM);
      lpa_nxt = 16'h0000;
      lp_able_nxt = 1'b0;
      pd_fault_nxt = 1'b0;
      an_done_nxt = 1'b0;
    end
  end

  always_comb begin
    link_up = (an_st_r == AN_LINK) || (an_st_r == AN_OFF && !an_en_r && !i_signal_lost);
    link_nxt.link_up = link_up;
    // Forced bits only matter with negotiation off
    link_nxt.speed_100 = an_en_r ? res_r[1] : speed_r;
    link_nxt.full_duplex = an_en_r ? res_r[0] : duplex_r;
    link_nxt.an_complete = an_done_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      an_st_r <= AN_OFF;
      strap_r <= i_straps;
      an_en_r <= CTRL_AN_EN_RST;
      speed_r <= CTRL_SPEED_RST;
      duplex_r <= CTRL_DUPLEX_RST;
      adv_r <= ADV_RST | (16'(i_straps.pause_asym) << ADV_ASYM) | (16'(i_straps.pause_sym) << ADV_SYM);
      lpa_r <= 16'h0000;
      lp_able_r <= 1'b0;
      pd_fault_r <= 1'b0;
      spec_r <= 3'h0;
      pdcfg_r <= 2'h0;
      res_r <= 2'h0;
      an_done_r <= 1'b0;
      tmr_r <= '0;
      link_r <= '0;
    end else begin
      an_st_r <= an_st_nxt;
      strap_r <= strap_nxt;
      an_en_r <= an_en_nxt;
      speed_r <= speed_nxt;
      duplex_r <= duplex_nxt;
      adv_r <= adv_nxt;
      lpa_r <= lpa_nxt;
      lp_able_r <= lp_able_nxt;
      pd_fault_r <= pd_fault_nxt;
      spec_r <= spec_nxt;
      pdcfg_r <= pdcfg_nxt;
      res_r <= res_nxt;
      an_done_r <= an_done_nxt;
      tmr_r <= tmr_nxt;
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Crossover selection
  // ----------------------------------------------------------------
  always_comb begin
    logic auto_en;
    logic fixed_state;
    logic extend;
    logic [TIMER_W-1:0] period;
    auto_en = spec_r[2] ? spec_r[1] : (|strap_r.auto_mdix);
    fixed_state = spec_r[2] ? spec_r[0] : strap_r.manual_mdix[0];
    extend = (!an_en_r && pdcfg_r[PDCFG_EXT_MAN]) || (i_energy_detect_power_down_enable && pdcfg_r[PDCFG_EXT_ENERGY_DETECT_POWER_DOWN]);
    period = extend ? TIMER_W'(2 * SWITCH_CYC) : TIMER_W'(SWITCH_CYC);
    swap_nxt = swap_r;
    sw_tmr_nxt = '0;
    if (i_fx_mode) begin
      swap_nxt = 1'b0;
    end else if (!auto_en) begin
      swap_nxt = fixed_state;
    end else if (!link_up && !i_partner_pairs_found) begin
      // Hunt by toggling until the partner's pairs are found
      sw_tmr_nxt = sw_tmr_r + TIMER_W'(1);
      if (sw_tmr_r >= period - TIMER_W'(1)) begin
        swap_nxt = ~swap_r;
        sw_tmr_nxt = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      swap_r <= 1'b0;
      sw_tmr_r <= '0;
    end else begin
      swap_r <= swap_nxt;
      sw_tmr_r <= sw_tmr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_mdio = out_r;
  assign o_mdio_oe = oe_r;
  assign o_link = link_r;
  assign o_lcw = adv_r | (16'(an_st_r == AN_ACK) << LCW_ACK);
  assign o_lcw_send = (an_st_r == AN_LISTEN) || (an_st_r == AN_ACK);
  assign o_txrx_halt = (an_st_r == AN_BREAK);
  assign o_crs = !o_txrx_halt && (i_rx_active || (!link_r.full_duplex && i_tx_active));
  assign o_col = !o_txrx_halt && !link_r.full_duplex && i_tx_active && i_rx_active;
  assign o_mdix_swap = swap_r;
endmodule // pal_link_ctrl

// *** dv/pal_link_ctrl_monitor.sv ***
// Port assertions of the PHY link control block
`timescale 1ns/1ps
module pal_link_ctrl_monitor #(
  parameter int BREAK_CYC = pal_pkg::BREAK_LINK_CYC
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_reset, // Sync reset
  input wire logic i_tx_active, // Tx activity
  input wire logic i_rx_active, // Rx activity
  input wire logic i_fx_mode, // Fibre mode
  input wire logic o_mdio, // Data out
  input wire logic o_mdio_oe, // Data drive
  input wire pal_pkg::pal_link_stat_t o_link, // Link status
  input wire logic o_lcw_send, // Bursts on
  input wire logic o_txrx_halt, // Break wait
  input wire logic o_crs, // Carrier sense
  input wire logic o_col, // Collision
  input wire logic o_mdix_swap // Swap
);
  import pal_pkg::*;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  int halt_cnt_r;
  int halt_cnt_nxt;
  always_comb begin
    halt_cnt_nxt = o_txrx_halt ? halt_cnt_r + 1 : 0;
  end
  always_ff @(posedge i_ref_clk) begin
    halt_cnt_r <= i_reset ? 0 : halt_cnt_nxt;
  end
  sequence s_release;
    $fell(i_reset);
  endsequence
  sequence s_halt_end;
    $fell(o_txrx_halt);
  endsequence
  reset_quiet_a: assert property (s_release |-> o_link == '0 && !o_mdio_oe && !o_txrx_halt && !o_mdix_swap)
    else $error("outputs not idle after reset");
  start_send_a: assert property (s_release |=> o_lcw_send)
    else $error("negotiation not started after reset");
  halt_len_a: assert property (s_halt_end |-> halt_cnt_r == BREAK_CYC)
    else $error("link break length wrong");
  halt_quiet_a: assert property (o_txrx_halt |-> !o_lcw_send)
    else $error("bursts sent during link break");
  full_crs_a: assert property (o_link.full_duplex |-> o_crs == (i_rx_active && !o_txrx_halt) && !o_col)
    else $error("full duplex carrier or collision wrong");
  half_crs_a: assert property (o_link.link_up && !o_link.full_duplex |->
    o_crs == ((i_tx_active | i_rx_active) && !o_txrx_halt) &&
    o_col == ((i_tx_active & i_rx_active) && !o_txrx_halt))
    else $error("half duplex carrier or collision wrong");
  fibre_swap_a: assert property (i_fx_mode [*2] |-> !o_mdix_swap)
    else $error("pair swap in fibre mode");
  ta_zero_a: assert property ($rose(o_mdio_oe) |-> !o_mdio)
    else $error("turnaround not driven low");
endmodule // pal_link_ctrl_monitor
bind pal_link_ctrl pal_link_ctrl_monitor #(.BREAK_CYC(BREAK_CYC)) mon (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_tx_active(i_tx_active), .i_rx_active(i_rx_active),
  .i_fx_mode(i_fx_mode), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_link(o_link), .o_lcw_send(o_lcw_send),
  .o_txrx_halt(o_txrx_halt), .o_crs(o_crs), .o_col(o_col), .o_mdix_swap(o_mdix_swap));

// *** dv/pal_mgmt_model.sv ***
// Management controller model driving serial frames
`timescale 1ns/1ps
module pal_mgmt_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_mdio, // Resolved wire
  output logic o_mdc, // Management clock
  output logic o_mdio // Data, 1 when released
);
  import pal_pkg::*;
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
  end
  // Slow clock: 2 low, 3 high; the port answers one clock after each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [35:0] f;
    logic r;
    f = {4'b1101, op, PHY_ADDR_RST, rg, (op == OP_WRITE) ? {2'b10, wd} : 18'h3ffff, 2'b11};
    rd = 16'h0000;
    for (int i = 35; i >= 0; i--) begin
      o_mdc <= 1'b0;
      o_mdio <= f[i];
      repeat (2) @(posedge i_ref_clk);
      // Taken as the clock rises, before the port reacts to this rise
      r = i_mdio;
      o_mdc <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      if (i <= 17 && i >= 2) begin
        rd = {rd[14:0], r};
      end
    end
  endtask
endmodule // pal_mgmt_model

// *** dv/pal_link_ctrl_tb_top.sv ***
// Self-checking bench of the PHY link control block
`timescale 1ns/1ps
module pal_link_ctrl_tb_top;
  import pal_pkg::*;
  localparam int BRK = 20;
  localparam int SW = 10;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  pal_strap_t straps = '0;
  logic ldr = 1'b0, fv = 1'b0, pd100 = 1'b0, pd10 = 1'b0, pdf = 1'b0, lost = 1'b0;
  logic tx = 1'b0, rx = 1'b0, fx = 1'b0, energy_detect_power_down = 1'b0, pairs = 1'b0;
  logic [15:0] fw = 16'h0000;
  logic mdc, mm, dm, doe, mw, lsend, halt, crs, col, swap;
  pal_link_stat_t lk;
  logic [15:0] lcw, rd;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  // Released wire reads 1 from the model's own drive
  assign mw = doe ? dm : mm;
  pal_mgmt_model mdl (.i_ref_clk(i_ref_clk), .i_mdio(mw), .o_mdc(mdc), .o_mdio(mm));
  pal_link_ctrl #(.BREAK_CYC(BRK), .SWITCH_CYC(SW)) dut (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_straps(straps), .i_loader_done(ldr),
    .i_flp_word_valid(fv), .i_flp_word(fw), .i_pd_100_seen(pd100), .i_pd_10_seen(pd10),
    .i_pd_fault(pdf), .i_signal_lost(lost), .i_tx_active(tx), .i_rx_active(rx), .i_fx_mode(fx),
    .i_energy_detect_power_down_enable(energy_detect_power_down), .i_partner_pairs_found(pairs), .i_mdc(mdc), .i_mdio(mw), .o_mdio(dm),
    .o_mdio_oe(doe), .o_link(lk), .o_lcw(lcw), .o_lcw_send(lsend), .o_txrx_halt(halt),
    .o_crs(crs), .o_col(col), .o_mdix_swap(swap));
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    tx <= 1'($urandom_range(1));
    rx <= 1'($urandom_range(1));
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic rdr(input logic [4:0] a);
    mdl.frame(OP_READ, a, 16'hffff, rd);
  endtask
  task automatic wrr(input logic [4:0] a, input logic [15:0] v);
    mdl.frame(OP_WRITE, a, v, rd);
  endtask
  task automatic word(input logic [15:0] w);
    fw <= w;
    fv <= 1'b1;
    tick(1);
    fv <= 1'b0;
    tick(3);
  endtask
  task automatic period(output int p);
    logic s;
    for (int t = 0; t < 2; t++) begin
      s = swap;
      p = 0;
      while (swap === s && p < 100) begin
        tick(1);
        p++;
      end
    end
  endtask
  function automatic logic [15:0] lnk();
    lnk = {13'h0, lk.link_up, lk.speed_100, lk.full_duplex};
  endfunction
  function automatic logic [15:0] res(input logic [3:0] ab);
    res = {13'h0, 1'b1, ab[3] | ab[2], ab[3] | (~ab[2] & ab[1])};
  endfunction
  initial begin
    logic [15:0] w;
    logic [3:0] ab;
    logic s;
    int p;
    void'($urandom(1239));
    straps = {2'($urandom_range(3)), 4'b0100};
    tick(5);
    i_reset <= 1'b0;
    tick(2);
    rdr(REG_ADV);
    chk(rd, ADV_RST | {4'h0, straps.pause_asym, straps.pause_sym, 10'h000});
    rdr(5'h0a);
    chk(rd, UNMAPPED_VAL);
    for (int k = 0; k < 4; k++) begin
      ab = 4'($urandom_range(15, 1));
      w = {7'h00, ab, 5'h01};
      word(w);
      chk(16'(lcw[LCW_ACK]), 16'h0001);
      if (k == 0) begin
        word(w ^ 16'h0400);
        chk(16'(lcw[LCW_ACK]), 16'h0000);
        word(w);
      end
      word(w | 16'h4000);
      chk(lnk(), res(ab));
      chk(16'(lk.an_complete), 16'h0001);
      rdr(REG_STAT);
      chk(rd, STAT_CAPS | 16'h0024);
      lost <= 1'b1;
      tick(3);
      chk(16'(lsend), 16'h0001);
      lost <= 1'b0;
    end
    for (int j = 0; j < 2; j++) begin
      pdf <= 1'b1;
      pd10 <= (j == 0);
      pd100 <= (j == 1);
      tick(1);
      pdf <= 1'b0;
      tick(3);
      chk(lnk(), {13'h0, 1'b1, j[0], 1'b0});
      rdr(REG_EXP);
      chk(rd & 16'h0011, 16'h0010);
      rdr(REG_EXP);
      chk(rd & 16'h0010, 16'h0000);
      rdr(REG_LPA);
      chk(rd, LPA_SELECTOR | ((j == 0) ? 16'h0020 : 16'h0080));
      pd10 <= 1'b0;
      pd100 <= 1'b0;
      lost <= 1'b1;
      tick(3);
      lost <= 1'b0;
    end
    wrr(REG_CTRL, 16'h3200);
    for (int n = 0; n < 20 && halt !== 1'b1; n++) tick(1);
    chk(16'({halt, lsend}), 16'h0002);
    tick(BRK + 2);
    chk(16'({halt, lsend}), 16'h0001);
    for (int m = 0; m < 4; m++) begin
      wrr(REG_CTRL, {2'b00, m[1], 4'h0, m[0], 8'h00});
      tick(3);
      chk(lnk(), {13'h0, 1'b1, m[1:0]});
      chk(16'(lk.an_complete), 16'h0000);
    end
    lost <= 1'b1;
    wrr(REG_SPEC, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      energy_detect_power_down <= (k == 2);
      wrr(REG_PDCFG, (k == 0) ? 16'h0000 : ((k == 1) ? 16'h0002 : 16'h0001));
      period(p);
      chk(16'(p), 16'((k == 0) ? SW : 2 * SW));
    end
    pairs <= 1'b1;
    tick(2);
    s = swap;
    tick(4 * SW);
    chk(16'(swap), 16'(s));
    pairs <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      fx <= (k == 2);
      wrr(REG_SPEC, (k == 0) ? 16'h8000 : 16'ha000);
      tick(3);
      chk(16'(swap), 16'(k == 1));
    end
    fx <= 1'b0;
    lost <= 1'b0;
    wrr(REG_CTRL, 16'h1000);
    pd10 <= 1'b1;
    tick(4);
    pd10 <= 1'b0;
    chk(16'(lsend), 16'h0000);
    ldr <= 1'b1;
    tick(1);
    ldr <= 1'b0;
    tick(3);
    chk(16'(lsend), 16'h0001);
    conclude();
  end
endmodule // pal_link_ctrl_tb_top
